// [logic/ebram_core.sv]
// Embedded synchronous RAM: registered write path with lane masking,
// synchronous read and an optional output register.
// Assumes all inputs are synchronous to sys_clk_i; the clears may be
// asserted at any time and are released synchronously by the fabric.
`include "ebram_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ebram_core #(
  parameter ebram_pkg::ebram_kind_type KIND    = ebram_pkg::EBR_MID,
  parameter int                        DATA_W  = `EBR_DEF_DATA_W,
  parameter int                        DEPTH   = `EBR_DEF_DEPTH,
  parameter bit                        PARITY  = 1'b1,
  parameter bit                        OUT_REG = 1'b1
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         in_clr_i,
  input  wire logic                         out_clr_i,
  input  wire ebram_pkg::ebram_wr_req_type  wr_req_i,
  input  wire logic [`EBR_MASK_BUS_W-1:0]   lane_mask_lo_i,
  input  wire logic [`EBR_MASK_BUS_W-1:0]   lane_mask_hi_i,
  input  wire logic [`EBR_ADDR_W-1:0]       rd_addr_i,
  output logic      [DATA_W-1:0]            rd_data_o
);
  import ebram_pkg::*;

  // Which widths let a block type mask bytes
  function automatic bit mask_capable(input ebram_kind_type k, input int w);
    bit ok;
    ok = 1'b0;
    case (k)
      EBR_MID:   ok = (w == `EBR_W16) || (w == `EBR_W18) || (w == `EBR_W32) || (w == `EBR_W36);
      EBR_LARGE: ok = (w == `EBR_W16) || (w == `EBR_W18) || (w == `EBR_W32) || (w == `EBR_W36) ||
                      (w == `EBR_W64) || (w == `EBR_W72) || (w == `EBR_W128) || (w == `EBR_W144);
      default:   ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Ninth bit per byte is stored but never interpreted here
  localparam int BYTE_W  = PARITY ? `EBR_BYTE_W_PARITY : `EBR_BYTE_W_PLAIN;
  localparam int LANES   = DATA_W / BYTE_W;
  localparam int ADDR_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam bit MASK_OK = mask_capable(KIND, DATA_W);
  localparam bit WIDE    = (DATA_W >= `EBR_W128);

  // Replace the lanes whose mask bit is set, keep the rest
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0]         old_w,
                                                   input logic [DATA_W-1:0]         new_w,
                                                   input logic [`EBR_MASK_ALL_W-1:0] m);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int n = 0; n < LANES; n++)
    begin
      if (m[n])
      begin
        r[n*BYTE_W +: BYTE_W] = new_w[n*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // Storage array, parity bits included in each row
  logic [DATA_W-1:0] mem [DEPTH];

  logic                       in_clear;
  logic                       out_clear;
  logic [ADDR_W-1:0]          wr_addr_q;
  logic [DATA_W-1:0]          wr_data_q;
  logic                       wr_en_q;
  logic [`EBR_MASK_BUS_W-1:0] mask_lo_q;
  logic [`EBR_MASK_BUS_W-1:0] mask_hi_q;
  logic [ADDR_W-1:0]          rd_addr_q;
  logic [`EBR_MASK_ALL_W-1:0] eff_mask;
  logic [DATA_W-1:0]          rd_word;
  logic [DATA_W-1:0]          out_q;

  // Clears merged with the global reset
  assign in_clear  = rst_i | in_clr_i;
  assign out_clear = rst_i | out_clr_i;

  // Address, data and strobe input registers, cleared at once
  always_ff @(posedge sys_clk_i or posedge in_clear)
  begin
    if (in_clear)
    begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_en_q   <= 1'b0;
      rd_addr_q <= '0;
    end
    else
    begin
      wr_addr_q <= wr_req_i.addr[ADDR_W-1:0];
      wr_data_q <= wr_req_i.data[DATA_W-1:0];
      wr_en_q   <= wr_req_i.strobe;
      rd_addr_q <= rd_addr_i[ADDR_W-1:0];
    end
  end

  // Lane mask registers clear high so a cleared mask never blocks a write
  always_ff @(posedge sys_clk_i or posedge in_clear)
  begin
    if (in_clear)
    begin
      mask_lo_q <= `EBR_MASK_RESET;
      mask_hi_q <= `EBR_MASK_RESET;
    end
    else
    begin
      mask_lo_q <= lane_mask_lo_i;
      mask_hi_q <= lane_mask_hi_i;
    end
  end

  // Mask actually applied; unsupported widths always write whole words
  always_comb
  begin
    if (!MASK_OK)
    begin
      eff_mask = `EBR_MASK_ALL_ONES;
    end
    else if (WIDE)
    begin
      eff_mask = {mask_hi_q, mask_lo_q};
    end
    else
    begin
      eff_mask = {`EBR_MASK_RESET, mask_lo_q};
    end
  end

  // Array write: strobe gates everything, mask picks lanes
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_q)
    begin
      mem[wr_addr_q] <= lane_merge(mem[wr_addr_q], wr_data_q, eff_mask);
    end
  end

  // Synchronous read; an input clear is seen only through this edge
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_word <= '0;
    end
    else
    begin
      rd_word <= mem[rd_addr_q];
    end
  end

  // Output register, cleared without waiting for a clock
  always_ff @(posedge sys_clk_i or posedge out_clear)
  begin
    if (out_clear)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= rd_word;
    end
  end

  // Bypassing the output register trades timing for one cycle less of read latency
  assign rd_data_o = OUT_REG ? out_q : rd_word;

  // Helper logic for the checks: word under the write address before and after
  logic [DATA_W-1:0]          cur_word;
  logic [DATA_W-1:0]          word0;
  logic [DATA_W-1:0]          post_word;
  logic                       prev_valid;
  logic [ADDR_W-1:0]          prev_addr;
  logic [DATA_W-1:0]          prev_word;
  logic [DATA_W-1:0]          prev_data;
  logic [`EBR_MASK_ALL_W-1:0] prev_mask;
  logic                       prev_wen;

  assign cur_word  = mem[wr_addr_q];
  assign word0     = mem[0];
  assign post_word = mem[prev_addr];

  // Snapshot of each edge's write operands
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_valid <= 1'b0;
      prev_addr  <= '0;
      prev_word  <= '0;
      prev_data  <= '0;
      prev_mask  <= '0;
      prev_wen   <= 1'b0;
    end
    else
    begin
      prev_valid <= 1'b1;
      prev_addr  <= wr_addr_q;
      prev_word  <= cur_word;
      prev_data  <= wr_data_q;
      prev_mask  <= eff_mask;
      prev_wen   <= wr_en_q;
    end
  end

  // Steps of a checked write
  sequence s_write_taken;
    prev_valid && prev_wen;
  endsequence

  sequence s_idle_edge;
    prev_valid && !prev_wen;
  endsequence

  a_masked_merge: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    s_write_taken |-> post_word === lane_merge(prev_word, prev_data, prev_mask))
    else $error("masked write did not merge lanes correctly");

  a_strobe_low_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    s_idle_edge |-> post_word === prev_word)
    else $error("location changed with write strobe low");

  a_mask_clear_high: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    in_clr_i |-> (mask_lo_q == `EBR_MASK_RESET) && (mask_hi_q == `EBR_MASK_RESET))
    else $error("cleared lane mask not all high");

  a_mask_reset_default: assert property (
    @(posedge sys_clk_i)
    $past(rst_i) && !rst_i |-> &mask_lo_q && &mask_hi_q && !wr_en_q)
    else $error("lane mask not high after reset");

  a_in_clear_edge: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    in_clr_i ##1 in_clr_i |-> rd_word === $past(word0))
    else $error("input clear not seen as address zero at next edge");

  a_out_clear_now: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (out_clr_i && OUT_REG) |-> rd_data_o == '0)
    else $error("output clear not visible immediately");

  a_out_reg_follow: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (OUT_REG && !out_clr_i && !$past(out_clr_i) && !$past(rst_i)) |-> rd_data_o === $past(rd_word))
    else $error("output register did not follow read word");

  a_width_capable: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !MASK_OK |-> eff_mask == `EBR_MASK_ALL_ONES)
    else $error("byte mask applied at unsupported width");

  a_wide_concat: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (MASK_OK && WIDE) |-> eff_mask == {mask_hi_q, mask_lo_q})
    else $error("wide mode mask not concatenated");

endmodule

`default_nettype wire

// [logic/ebram_defines.svh]
// Constants for the byte-masked embedded RAM write path.
// Assumes inclusion by bare name from the package and the RAM module.
`ifndef EBRAM_DEFINES_SVH
`define EBRAM_DEFINES_SVH

// Byte sizes with and without the parity bit
`define EBR_BYTE_W_PARITY   9
`define EBR_BYTE_W_PLAIN    8
// Smallest block capacity, parity bits included
`define EBR_SMALL_BITS      576
`define EBR_SMALL_PAR_BITS  64
// Lane mask buses and the widest combined mask
`define EBR_MASK_BUS_W      8
`define EBR_MASK_ALL_W      16
`define EBR_MASK_RESET      8'hFF
`define EBR_MASK_ALL_ONES   16'hFFFF
// Carrier widths
`define EBR_MAX_DATA_W      144
`define EBR_ADDR_W          16
// Widths that allow byte masking
`define EBR_W16             16
`define EBR_W18             18
`define EBR_W32             32
`define EBR_W36             36
`define EBR_W64             64
`define EBR_W72             72
`define EBR_W128            128
`define EBR_W144            144
// Defaults for the instance
`define EBR_DEF_DATA_W      36
`define EBR_DEF_DEPTH       128

`endif

// [logic/ebram_pkg.sv]
// Types shared by the byte-masked embedded RAM.
// Assumes the defines header sits beside it on the include path.
`include "ebram_defines.svh"

package ebram_pkg;

  // Block sizes, which decide the legal masked widths
  typedef enum logic [1:0] {
    EBR_SMALL,
    EBR_MID,
    EBR_LARGE
  } ebram_kind_type;

  // One write request from fabric logic, data in low bits
  typedef struct packed {
    logic [`EBR_ADDR_W-1:0]     addr;
    logic [`EBR_MAX_DATA_W-1:0] data;
    logic                       strobe;
  } ebram_wr_req_type;

endpackage

// [testbench/ebram_fabric_par.sv]
// Fabric-side parity helper: builds 9-bit bytes and checks read words.
// Assumes 36-bit words, even parity in bit 9n+8 of each lane.
`timescale 1ns/10ps
`default_nettype none

module ebram_fabric_par (
  input  wire logic [31:0] payload_i,
  input  wire logic [35:0] rd_word_i,
  output logic      [35:0] word_o,
  output logic             par_err_o
);
  // RAM only stores the ninth bits, so making and checking them is ours
  always_comb
  begin
    par_err_o = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      word_o[9*n+:9] = {^payload_i[8*n+:8], payload_i[8*n+:8]};
      par_err_o      = par_err_o | (^rd_word_i[9*n+:9]);
    end
  end
endmodule
`default_nettype wire

// [testbench/ebram_core_tb_top.sv]
// Self-checking bench for the byte-masked RAM, mid-size block, 36 bits.
// Assumes the design's default read latency of three edges.
`timescale 1ns/10ps
`default_nettype none

module ebram_core_tb_top;
  import ebram_pkg::*;
  logic             sys_clk, rst, in_clr, out_clr;
  ebram_wr_req_type req;
  logic [7:0]       mask_lo;
  logic [15:0]      rd_addr;
  logic [35:0]      rd_data, pword;
  logic [31:0]      payload;
  logic             perr;
  int               fails, num_checks;

  ebram_core dut (.sys_clk_i(sys_clk), .rst_i(rst), .in_clr_i(in_clr), .out_clr_i(out_clr),
    .wr_req_i(req), .lane_mask_lo_i(mask_lo), .lane_mask_hi_i(8'hFF), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data));
  ebram_fabric_par fab (.payload_i(payload), .rd_word_i(rd_data), .word_o(pword), .par_err_o(perr));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One write request, strobe dropped at the edge that takes it
  task wr(input logic [15:0] a, input logic [35:0] d, input logic [7:0] m, input logic s);
    @(posedge sys_clk);
    req.addr   <= a;
    req.data   <= {108'h0, d};
    req.strobe <= s;
    mask_lo    <= m;
    @(posedge sys_clk);
    req.strobe <= 1'b0;
  endtask

  // Address held until the output flop has caught up
  task rd(input logic [15:0] a, output logic [35:0] q);
    @(posedge sys_clk);
    rd_addr <= a;
    repeat (4) @(posedge sys_clk);
    #1 q = rd_data;
  endtask

  // Parity word from fabric goes in whole and comes back intact
  task t_parity;
    logic [35:0] q;
    payload = 32'hC3A5_0F96;
    #1 wr(16'h0003, pword, 8'hFF, 1'b1);
    rd(16'h0003, q);
    chk(q, 36'h6_1A94_1E96);
    chk({35'h0, perr}, 36'h0);
  endtask

  // Every lane pattern over a known old word
  task t_lanes;
    logic [35:0] q, e, nw;
    nw = 36'h1_2345_6789;
    for (int m = 0; m < 16; m++)
    begin
      wr(16'h0010, 36'hF_FFFF_FFFF, 8'hFF, 1'b1);
      wr(16'h0010, nw, {4'h0, m[3:0]}, 1'b1);
      for (int n = 0; n < 4; n++)
        e[9*n+:9] = m[n] ? nw[9*n+:9] : 9'h1FF;
      rd(16'h0010, q);
      chk(q, e);
    end
  endtask

  // Strobe low with all lanes on leaves the row alone
  task t_nostrobe;
    logic [35:0] q;
    wr(16'h0020, 36'hA_5A5A_5A5A, 8'hFF, 1'b1);
    wr(16'h0020, 36'h0_0000_0000, 8'hFF, 1'b0);
    rd(16'h0020, q);
    chk(q, 36'hA_5A5A_5A5A);
  endtask

  // Output clear acts at once; input clear only after clock edges
  task t_clears;
    logic [35:0] q;
    wr(16'h0000, 36'h3_0C0C_0C0C, 8'hFF, 1'b1);
    wr(16'h0009, 36'h9_8765_4321, 8'hFF, 1'b1);
    rd(16'h0009, q);
    @(posedge sys_clk);
    out_clr <= 1'b1;
    #1 chk(rd_data, 36'h0);
    @(posedge sys_clk);
    out_clr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(rd_data, 36'h9_8765_4321);
    @(posedge sys_clk);
    in_clr <= 1'b1;
    #1 chk(rd_data, 36'h9_8765_4321);
    repeat (4) @(posedge sys_clk);
    #1 chk(rd_data, 36'h3_0C0C_0C0C);
    @(posedge sys_clk);
    in_clr <= 1'b0;
  endtask

  initial
  begin
    fails = 0;
    num_checks = 0;
    rst = 1'b1;
    in_clr = 1'b0;
    out_clr = 1'b0;
    req = '0;
    mask_lo = 8'hFF;
    rd_addr = 16'h0;
    payload = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_parity();
    t_lanes();
    t_nostrobe();
    t_clears();
    wrap_up();
  end

  // Run needs roughly 180 cycles; cut off far beyond that
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
